// ### common/clkgen_regs.svh
// Purpose: Shared slot numbers, reset values and default counts for the clock generator.
// Assumes: One slot is one oscillator period; nine slots make one processor cycle.
// Notes:   Definitions only; included by bare name.
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// Last slot of the modulo-nine counter; the counter wraps to zero after it.
`define SLOT_LAST      4'h8
// Last slot in which the first phase is high (slots 0 and 1).
`define PH1_END        4'h1
// First and last slots in which the second phase is high (slots 2 to 6).
`define PH2_START      4'h2
`define PH2_END        4'h6
// Slot whose end samples the first-state flag while status sits on the bus.
`define STATUS_SLOT    4'h6
// Slot whose end retimes ready and reset; lies inside the second phase.
`define RETIME_SLOT    4'h3
// Default number of clock cycles in one oscillator period.
`define OSC_DIV_DEF    2
// Default number of agreeing samples before the reset input changes state.
`define POR_FILTER_DEF 8
// Value the counter restarts from, so the first slot after reset is slot 0.
`define SLOT_RESET     4'h8

`endif

// ### common/clkgen_pkg.sv
// Purpose: Types shared by the clock generator and its input conditioner.
// Assumes: Widths below bound the module parameters; the modules check them.
// Notes:   Holds types only; numbers live in the header.
package clkgen_pkg;

  // Slot number within one processor cycle.
  typedef logic [3:0] slot_t;
  // Generic small counter used for the oscillator divider and input filter.
  typedef logic [7:0] count_t;

  // Whole state of the generator, registered in one process.
  typedef struct packed {
    slot_t  slot;      // Current oscillator period within the cycle.
    count_t div;       // Clock cycles into the current oscillator period.
    logic   osc;       // Oscillator copy.
    logic   ph_first;  // First phase clock.
    logic   ph_second; // Second phase clock.
    logic   ph_copy;   // Logic-level copy of the second phase.
    logic   strobe_n;  // Status strobe, active low.
    logic   ready;     // Retimed ready.
    logic   reset;     // Processor reset.
  } gen_state_t;

  // Whole state of one input conditioner.
  typedef struct packed {
    logic   meta;      // First synchroniser stage.
    logic   sync;      // Second synchroniser stage.
    logic   level;     // Filtered level.
    count_t run;       // Samples seen disagreeing with the level.
  } cond_state_t;

endpackage : clkgen_pkg

// ### src/input_conditioner.sv
// Purpose: Two-flop synchroniser followed by a hysteresis filter on one input.
// Assumes: raw_in may change at any time relative to clk_in.
// Notes:   FILTER_LEN of 1 gives a plain synchroniser with no filtering.
module input_conditioner
  import clkgen_pkg::*;
#(
  parameter int unsigned FILTER_LEN = 1,
  parameter logic        INIT       = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic raw_in,
  output logic      level_out
);

  // The run counter is eight bits wide, so longer filters cannot be served.
  if (FILTER_LEN < 1 || FILTER_LEN > 255) begin : g_bad_len
    $error("input_conditioner: FILTER_LEN must be 1 to 255");
  end

  localparam count_t RUN_LAST = count_t'(FILTER_LEN - 1);

  cond_state_t s_q;  // Registered state.
  cond_state_t s_d;  // Next state.

  // The level only moves after FILTER_LEN agreeing samples, which gives
  // the same immunity to a slow or bouncing edge as a threshold with hysteresis.
  always_comb begin
    s_d      = s_q;
    s_d.meta = raw_in;
    s_d.sync = s_q.meta;
    if (s_q.sync == s_q.level) begin
      // Agreement clears any partial run.
      s_d.run = '0;
    end else if (s_q.run == RUN_LAST) begin
      // Enough disagreeing samples: accept the new level.
      s_d.level = s_q.sync;
      s_d.run   = '0;
    end else begin
      s_d.run = s_q.run + 8'h01;
    end
  end

  // Synchronous reset loads the INIT level into every stage.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q <= '{meta: INIT, sync: INIT, level: INIT, run: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;

endmodule : input_conditioner

// ### src/two_phase_clock_generator.sv
// Purpose: Two-phase processor clock generator with status strobe, reset and ready.
// Assumes: clk_in stands for the crystal; OSC_DIV clock cycles make one oscillator period.
// Notes:   All outputs are registered; all but the oscillator copy change on the same clock as the slot counter, phases and copy decoded from the next slot.
//
// Overview of operation
// - Modulo-nine counter sets every phase and timing but the oscillator copy.
// - Phase one two, phase two five, then two low.
// - Oscillator copy driven on its own output.
// - Logic-level copy of second phase driven out.
// - Strobe low once status is stable on bus.
// - Strobe held low during power-on reset.
// - Filtered low reset input asserts processor reset.
// - Asynchronous wait request retimed into ready.
`include "clkgen_regs.svh"

module two_phase_clock_generator
  import clkgen_pkg::*;
#(
  parameter int unsigned OSC_DIV    = `OSC_DIV_DEF,
  parameter int unsigned POR_FILTER = `POR_FILTER_DEF
) (
  input  wire logic clk_in,                      // System clock, stands for the crystal.
  input  wire logic rstn_in,                     // Synchronous reset, active low.
  input  wire logic power_on_reset_in_n,         // RC reset input, active low.
  input  wire logic wait_request_in,             // Asynchronous ready request, high = ready.
  input  wire logic machine_cycle_start_in,      // High in the first state of a cycle.
  output logic      first_phase_clock_out,       // First phase clock.
  output logic      second_phase_clock_out,      // Second phase clock.
  output logic      second_phase_logic_copy_out, // Copy of the second phase.
  output logic      oscillator_out,              // Oscillator copy.
  output logic      status_strobe_n_out,         // Status strobe, active low.
  output logic      ready_out,                   // Retimed ready.
  output logic      processor_reset_out          // Processor reset, active high.
);

  // The oscillator must split into two equal halves, and the divider is eight bits.
  if (OSC_DIV < 2 || OSC_DIV > 256 || (OSC_DIV % 2) != 0) begin : g_bad_div
    $error("two_phase_clock_generator: OSC_DIV must be even, 2 to 256");
  end

  localparam count_t DIV_LAST = count_t'(OSC_DIV - 1);  // Last count of one period.
  localparam count_t DIV_HALF = count_t'(OSC_DIV / 2);  // Counts spent high.

  gen_state_t s_q;        // Registered state.
  gen_state_t s_d;        // Next state.
  logic       tick;       // Last clock of an oscillator period.
  logic       por_level;  // Filtered reset input, low while reset is requested.
  logic       wait_level; // Synchronised wait request.

  // The reset input goes through a filter, standing in for the threshold with
  // hysteresis; a slow supply ramp or a bouncing switch gives one clean edge.
  input_conditioner #(
    .FILTER_LEN (POR_FILTER),
    .INIT       (1'b0)
  ) u_por_cond (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .raw_in    (power_on_reset_in_n),
    .level_out (por_level)
  );

  // The wait request may change at any moment, so it is synchronised first.
  input_conditioner #(
    .FILTER_LEN (1),
    .INIT       (1'b0)
  ) u_wait_cond (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .raw_in    (wait_request_in),
    .level_out (wait_level)
  );

  // One-cycle enable marking the end of an oscillator period.
  // It is the only rate enable; the slot counter and every decode but the oscillator copy move on it.
  assign tick = (s_q.div == DIV_LAST);

  // Next-state logic: divider, slot counter, phases, strobe and retiming.
  always_comb begin
    s_d = s_q;
    // Divider and oscillator copy, high for the first half of each period.
    s_d.div = tick ? '0 : s_q.div + 8'h01;
    s_d.osc = (s_d.div < DIV_HALF);
    if (tick) begin
      // Modulo-nine slot counter; every other signal but the oscillator copy is decoded from it.
      s_d.slot = (s_q.slot == `SLOT_LAST) ? '0 : s_q.slot + 4'h1;
      // Fixed 2-5-2 pattern; the phases can never overlap.
      s_d.ph_first  = (s_d.slot <= `PH1_END);
      s_d.ph_second = (s_d.slot >= `PH2_START) && (s_d.slot <= `PH2_END);
      s_d.ph_copy   = s_d.ph_second;
      // The strobe falls right after the second phase, when the status byte is
      // stable, and only in cycles the processor marked as first state.
      if (s_q.slot == `STATUS_SLOT) begin
        s_d.strobe_n = !machine_cycle_start_in;
      end else begin
        s_d.strobe_n = 1'b1;
      end
      // Retime once per cycle, well inside the second phase, so both outputs
      // are settled long before its falling edge.
      if (s_q.slot == `RETIME_SLOT) begin
        s_d.ready = wait_level;
        s_d.reset = !por_level;
      end
    end
    // While reset is given the strobe stays low so the controller resets too.
    if (s_d.reset) begin
      s_d.strobe_n = 1'b0;
    end
  end

  // State register; reset holds the processor in reset with the clocks low.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q <= '{slot: `SLOT_RESET, div: '0, osc: 1'b0, ph_first: 1'b0, ph_second: 1'b0,
               ph_copy: 1'b0, strobe_n: 1'b0, ready: 1'b0, reset: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign first_phase_clock_out       = s_q.ph_first;
  assign second_phase_clock_out      = s_q.ph_second;
  assign second_phase_logic_copy_out = s_q.ph_copy;
  assign oscillator_out              = s_q.osc;
  assign status_strobe_n_out         = s_q.strobe_n;
  assign ready_out                   = s_q.ready;
  assign processor_reset_out         = s_q.reset;

  // Assertions and covers. They judge the waveform at the pins, so a wrong
  // slot decode shows up here even in cycles that the bench does not walk.
  localparam int CYC     = 9 * OSC_DIV;              // Clocks per processor cycle.
  localparam int P1_LEN  = 2 * OSC_DIV;              // Clocks of first phase.
  localparam int P2_LEN  = 5 * OSC_DIV;              // Clocks of second phase.
  localparam int OSC_LEN = OSC_DIV;                  // Clocks per oscillator period.
  localparam int RST_LAT = POR_FILTER + 4 + 2 * CYC; // Worst reset response.
  localparam int GAP_LEN = 2 * OSC_DIV;              // Clocks with both phases low.
  localparam int OSC_HI  = OSC_DIV / 2;              // Clocks the oscillator copy is high.

  int unsigned low_run;  // Clocks the reset input has been low without a break.

  // Helper counter read only by the assertions.
  always_ff @(posedge clk_in) begin
    if (!rstn_in || power_on_reset_in_n) begin
      low_run <= 0;
    end else if (low_run < RST_LAT) begin
      low_run <= low_run + 1;
    end
  end

  // Every property shares the one clock and reset silences them all, so the
  // first cycles after a release are judged only from clean history.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  cycle_length_a: assert property (
    $rose(first_phase_clock_out) |-> ##CYC $rose(first_phase_clock_out))
    else $error("processor cycle is not nine oscillator periods");

  phase_one_width_a: assert property (
    $rose(first_phase_clock_out) |->
      ##P1_LEN ($fell(first_phase_clock_out) && $rose(second_phase_clock_out)))
    else $error("first phase width or handover wrong");

  phase_two_width_a: assert property (
    $rose(second_phase_clock_out) |-> ##P2_LEN $fell(second_phase_clock_out))
    else $error("second phase width wrong");

  phase_overlap_a: assert property (
    !(first_phase_clock_out && second_phase_clock_out))
    else $error("phases overlap");

  osc_period_a: assert property (
    $rose(oscillator_out) |-> ##OSC_LEN $rose(oscillator_out))
    else $error("oscillator copy period wrong");

  phase_on_osc_a: assert property (
    $changed(second_phase_clock_out) |-> $rose(oscillator_out))
    else $error("phase moved off an oscillator edge");

  logic_copy_a: assert property (
    second_phase_logic_copy_out == second_phase_clock_out)
    else $error("logic copy differs from second phase");

  strobe_place_a: assert property (
    (!processor_reset_out && $fell(status_strobe_n_out)) |->
      !first_phase_clock_out && $past(second_phase_clock_out) ##OSC_LEN status_strobe_n_out)
    else $error("status strobe misplaced or wrong width");

  strobe_reset_a: assert property (
    processor_reset_out |-> !status_strobe_n_out)
    else $error("status strobe high during reset");

  reset_response_a: assert property (
    (low_run == RST_LAT) |-> processor_reset_out)
    else $error("reset input held low but no processor reset");

  retime_edge_a: assert property (
    ($changed(ready_out) || $changed(processor_reset_out)) |->
      second_phase_clock_out && $past(second_phase_clock_out))
    else $error("ready or reset changed outside the second phase");

  // Both phases stay low for two oscillator periods before the next cycle.
  phase_gap_a: assert property (
    $fell(second_phase_clock_out) |-> ##GAP_LEN $rose(first_phase_clock_out))
    else $error("gap between the phases has the wrong length");

  // The oscillator copy is high for the first half of each period only.
  osc_half_a: assert property (
    $rose(oscillator_out) |-> ##OSC_HI $fell(oscillator_out))
    else $error("oscillator copy high time wrong");

  // Outside reset the strobe may only be low while both phases are low.
  strobe_window_a: assert property (
    (!processor_reset_out && !status_strobe_n_out) |->
      !first_phase_clock_out && !second_phase_clock_out)
    else $error("status strobe low outside the phase gap");

  strobe_seen_c: cover property (
    !processor_reset_out ##1 $fell(status_strobe_n_out));

  reset_release_c: cover property ($fell(processor_reset_out));

  ready_rise_c: cover property ($rose(ready_out));

  reset_assert_c: cover property ($rose(processor_reset_out));

endmodule : two_phase_clock_generator

// ### sim/cpu_side_model.sv
// Purpose: Processor-side model that flags the first state of each machine cycle.
// Assumes: The flag is held from one first-phase pulse to the next.
// Notes:   Disabled before the last falling clock edge of a first phase, it does not flag that cycle, so no status strobe may appear.
module cpu_side_model (
  input  wire logic clk_in,                 // Bench clock.
  input  wire logic first_phase_clock_in,   // First phase from the generator.
  input  wire logic enable_in,              // High while machine cycles carry status.
  output logic      machine_cycle_start_out // High in the first state of a cycle.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial machine_cycle_start_out = 1'b0;

  // Update off the sampling edge, only while the first phase is high.
  always @(negedge clk_in) begin
    if (first_phase_clock_in) begin
      machine_cycle_start_out <= enable_in;
    end
  end
endmodule : cpu_side_model

// ### sim/two_phase_clock_generator_test.sv
// Purpose: Self-checking bench for the two-phase clock generator.
// Assumes: OSC_DIV of 2 and POR_FILTER of 2 keep every wait short.
// Notes:   Samples are taken on falling edges, counted from a first-phase rise.
module two_phase_clock_generator_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DIV = 2;       // Clocks per oscillator period.
  localparam int CYC = 9 * DIV; // Clocks per processor cycle.

  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic por_n = 1'b1;     // Reset input of the generator, active low.
  logic wait_req = 1'b0;  // Ready request.
  logic model_en = 1'b0;  // Lets the model flag status cycles.
  logic start, ph_one, ph_two, copy, osc, strobe_n, ready, preset;
  int   num_errors = 0;
  int   samples_checked = 0;
  int   cycles = 0;

  always #10 clk_in = ~clk_in;

  two_phase_clock_generator #(.OSC_DIV(DIV), .POR_FILTER(2)) u_two_phase_clock_generator (
    .clk_in                     (clk_in),
    .rstn_in                    (rstn_in),
    .power_on_reset_in_n        (por_n),
    .wait_request_in            (wait_req),
    .machine_cycle_start_in     (start),
    .first_phase_clock_out      (ph_one),
    .second_phase_clock_out     (ph_two),
    .second_phase_logic_copy_out(copy),
    .oscillator_out             (osc),
    .status_strobe_n_out        (strobe_n),
    .ready_out                  (ready),
    .processor_reset_out        (preset)
  );

  cpu_side_model u_cpu_side_model (
    .clk_in                 (clk_in),
    .first_phase_clock_in   (ph_one),
    .enable_in              (model_en),
    .machine_cycle_start_out(start)
  );

  // Prints the verdict and ends the run.
  task finish_test;
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Compares one sampled output with its expected level.
  task check(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : check

  // Returns at the falling edge just after the first phase rises; bounded waits.
  task sync_cycle;
    int n;
    n = 0;
    do @(negedge clk_in); while (ph_one !== 1'b0 && ++n < 40);
    do @(negedge clk_in); while (ph_one !== 1'b1 && ++n < 80);
  endtask : sync_cycle

  // Walks one whole cycle and checks every clock output and the strobe.
  task walk_cycle(input logic strobe_on);
    for (int k = 0; k < CYC; k++) begin
      if (k > 0) @(negedge clk_in);
      check("first_phase", k < 2 * DIV, ph_one);
      check("second_phase", k >= 2 * DIV && k < 7 * DIV, ph_two);
      check("phase_copy", k >= 2 * DIV && k < 7 * DIV, copy);
      check("oscillator", (k % DIV) < DIV / 2, osc);
      check("strobe_n", !(strobe_on && k >= 7 * DIV && k < 8 * DIV), strobe_n);
    end
  endtask : walk_cycle

  // Phases with no status cycles: the strobe must stay high.
  task test_phases;
    sync_cycle();
    check("proc_reset", 1'b0, preset);
    walk_cycle(1'b0);
  endtask : test_phases

  // Status cycles flagged back to back, then the flag withdrawn.
  task test_strobe;
    model_en = 1'b1;
    sync_cycle();
    walk_cycle(1'b1);
    @(negedge clk_in);
    walk_cycle(1'b1);
    model_en = 1'b0;
    sync_cycle();
    walk_cycle(1'b0);
  endtask : test_strobe

  // Ready rises and falls, changing only at the one retime point of the cycle.
  task test_ready;
    for (int v = 1; v >= 0; v--) begin
      // Change the request at the cycle start so it lands at this cycle's retime.
      sync_cycle();
      wait_req = v[0];
      for (int k = 0; k < CYC; k++) begin
        if (k > 0) @(negedge clk_in);
        check("ready", (k >= 4 * DIV) ? v[0] : !v[0], ready);
      end
    end
  endtask : test_ready

  // Reset input held low, then released; strobe held low meanwhile.
  task test_reset;
    por_n = 1'b0;
    sync_cycle();
    sync_cycle();
    check("proc_reset", 1'b1, preset);
    check("strobe_n", 1'b0, strobe_n);
    por_n = 1'b1;
    for (int k = 1; k < CYC; k++) begin
      @(negedge clk_in);
      check("proc_reset", k < 4 * DIV, preset);
      if (k < 4 * DIV) check("strobe_n", 1'b0, strobe_n);
      if (k >= 5 * DIV) check("strobe_n", 1'b1, strobe_n);
    end
  endtask : test_reset

  // Cuts a hang short; the whole run needs well under this many clocks.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end

  // Main sequence: two clocks of reset, then every scenario in turn.
  initial begin
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    check("strobe_n", 1'b0, strobe_n);
    // The processor reset only lifts at the first retime point, so it is still high at the first cycle start.
    sync_cycle();
    check("proc_reset", 1'b1, preset);
    test_phases();
    test_strobe();
    test_ready();
    test_reset();
    finish_test();
  end
endmodule : two_phase_clock_generator_test
